//--- lpmcs_pkg.sv
// constants shared by the low-power mode sequencer and its bench
package lpmcs_pkg;
  // register indices, byte address is four times the index
  localparam logic [11:0] LPMCS_IDX_MISC   = 12'h00c;
  localparam logic [11:0] LPMCS_IDX_LPFLAG = 12'h020;
  localparam logic [11:0] LPMCS_IDX_RAMV   = 12'h021;
  localparam logic [11:0] LPMCS_IDX_CSEL1  = 12'h029;
  localparam logic [11:0] LPMCS_IDX_CSEL2  = 12'h02a;
  localparam logic [11:0] LPMCS_IDX_MODE   = 12'h03f;
  localparam int          LPMCS_ADDR_W     = 12;

  // field positions
  localparam int LPMCS_LOW_SPEED_BIT   = 0;
  localparam int LPMCS_DIRECT_BIT      = 3;
  localparam int LPMCS_RAM_VALID_BIT   = 3;
  localparam int LPMCS_SUBDIV_BIT      = 2;
  localparam int LPMCS_SUBOSC_STOP_BIT = 3;
  localparam int LPMCS_FRAME_SEL_LSB   = 0;

  // values after reset
  localparam logic [3:0] LPMCS_MISC_RST   = 4'h0;
  localparam logic [3:0] LPMCS_LPFLAG_RST = 4'h0;
  localparam logic [3:0] LPMCS_RAMV_RST   = 4'h0;
  localparam logic [3:0] LPMCS_CSEL1_RST  = 4'h0;
  localparam logic [3:0] LPMCS_CSEL2_RST  = 4'h0;

  // system clock division codes (1/4, 1/8, 1/16, 1/32)
  localparam logic [1:0] LPMCS_DIV4  = 2'h0;
  localparam logic [1:0] LPMCS_DIV32 = 2'h3;

  // subsystem clock divide counts of the 32 kHz ticks
  localparam logic [2:0] LPMCS_SUBDIV8_LAST = 3'h7;
  localparam logic [2:0] LPMCS_SUBDIV4_LAST = 3'h3;

  // oscillator settling time and its count of core clocks
  localparam int LPMCS_CLK_PERIOD_NS = 5;
  localparam int LPMCS_OSC_SETTLE_NS = 1000000;
  localparam int LPMCS_OSC_SETTLE_CYC =
    (LPMCS_OSC_SETTLE_NS + LPMCS_CLK_PERIOD_NS - 1) / LPMCS_CLK_PERIOD_NS;

  // operating modes, one-hot
  typedef enum logic [5:0] {
    LPMCS_ACTIVE  = 6'h01,
    LPMCS_STANDBY = 6'h02,
    LPMCS_SUBACT  = 6'h04,
    LPMCS_WATCH   = 6'h08,
    LPMCS_STOP    = 6'h10,
    LPMCS_WAKE    = 6'h20
  } lpmcs_mode_e;
endpackage

//--- lpmcs_top.sv
// low-power mode sequencer and clock selection with an apb register port
`timescale 1ns/10ps
// Summary of operation
// - subactive stops main oscillator, runs on subclock, tone generator off.
// - subactive instruction cycle is 244 or 122 us by subclock divide bit.
// - subsystem clock is 32 kHz over 8 when bit clear, over 4 when set.
// - stop or standby in subactive goes to watch or active by the flags.
// - subclock drives frame prescaler; frame length picked by misc register.
// - timer and ext_irq0_n requests wait for the frame strobe only in watch and subactive.
// - ext_irq0_n falling edge counts at the second strobe after it.
// - direct transfer: clear low speed, set direct, sleep, then active alone.
// - direct flag settable only in subactive, forced clear in active.
// - direct transition takes over one settle time, under frame plus settle.
// - stop cancel returns to active and restarts at address zero.
// - ram valid reads 0 after reset exit, 1 after stop cancel exit.
// - reset ends every mode; stop cancel only acts in stop mode.
// - reset acts regardless of the current mode.
// - sleep with interrupts off and a pending unmasked flag is a no-op.
// - subclock oscillator stop bit halts it in stop mode only when set.
// - two-bit field selects system division 1/4, 1/8, 1/16 or 1/32.
// - division takes effect after watch mode; frequency bits at once.
// - after reset or stop exit division is 1/4 on pin high, 1/32 low.
// - watch exit by request goes active if low speed clear, else subactive.
module lpmcs_top
  import lpmcs_pkg::*;
#(
  parameter int unsigned SETTLE_CYC   = LPMCS_OSC_SETTLE_CYC,
  parameter int unsigned FRAME0_TICKS = 8,
  parameter int unsigned FRAME1_TICKS = 16,
  parameter int unsigned FRAME2_TICKS = 64
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [13:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              stop_instr,
  input  wire logic              standby_instr,
  input  wire logic              tma_watch_sel,
  input  wire logic              irq_enable_flag,
  input  wire logic              irq_pending,
  input  wire logic              stop_cancel_n,
  input  wire logic              ext_irq0_n,
  input  wire logic              tmr_a_ovf,
  input  wire logic              sub_osc_tick,
  input  wire logic              div_sel_pin,
  output logic      [5:0]        mode,
  output logic                   main_osc_on,
  output logic                   sub_osc_on,
  output logic                   tone_gen_on,
  output logic                   cpu_clk_on,
  output logic                   cpu_restart,
  output logic                   instr_nop,
  output logic                   sub_clk_en,
  output logic                   frame_strobe,
  output logic                   tma_irq_req,
  output logic                   ext_irq0_n_irq_req,
  output logic      [1:0]        sysdiv_eff,
  output logic      [3:0]        sysfreq_code
);

  localparam int CNT_W = $clog2(SETTLE_CYC + 1) + 1;
  localparam int FRM_W = $clog2(FRAME2_TICKS + FRAME1_TICKS + FRAME0_TICKS + 1);

  // all state of the block
  typedef struct packed {
    lpmcs_mode_e      mode;
    logic [3:0]       misc;
    logic [3:0]       lpflag;
    logic [3:0]       ramv;
    logic [3:0]       csel1;
    logic [3:0]       csel2;
    logic [1:0]       sysdiv;
    logic             strap_load;
    logic [CNT_W-1:0] settle_cnt;
    logic             wake_sync;
    logic             wake_restart;
    logic [FRM_W-1:0] frame_cnt;
    logic [2:0]       sub_cnt;
    logic             strobe;
    logic             sub_en;
    logic             tma_pend;
    logic             ext_irq0_n_s1;
    logic             ext_irq0_n_s2;
    logic             ext_irq0_n_prev;
    logic             tma_req;
    logic             ext_irq0_n_req;
    logic             restart;
    logic             nop;
    logic             main_on;
    logic             sub_on;
    logic             tone_on;
    logic             cpu_on;
    logic [31:0]      rdata;
    logic             ready;
  } lpmcs_state_s;

  lpmcs_state_s st_ff;
  lpmcs_state_s nxt_st;

  logic [11:0]      reg_idx;
  logic             acc_done;
  logic             sleep_req;
  logic             wake_req;
  logic [FRM_W-1:0] frame_last;

  // register index from the word address; the two low address bits are ignored
  assign reg_idx  = paddr[13:2];
  assign acc_done = psel & penable & st_ff.ready;
  assign sleep_req = stop_instr | standby_instr;

  // frame length from misc register, code 3 falls back to the longest frame
  always_comb begin
    case (st_ff.misc[LPMCS_FRAME_SEL_LSB +: 2])
      2'h0:    frame_last = FRM_W'(FRAME0_TICKS - 1);
      2'h1:    frame_last = FRM_W'(FRAME1_TICKS - 1);
      default: frame_last = FRM_W'(FRAME2_TICKS - 1);
    endcase
  end

  // next-state logic
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.restart  = 1'b0;
    nxt_st.nop      = 1'b0;
    nxt_st.strobe   = 1'b0;
    nxt_st.sub_en   = 1'b0;
    nxt_st.tma_req  = 1'b0;
    nxt_st.ext_irq0_n_req = 1'b0;
    wake_req        = 1'b0;

    // apb slave: one wait cycle, then ready for one cycle
    nxt_st.ready = psel & penable & ~st_ff.ready;
    if (psel & penable & ~st_ff.ready) begin
      case (reg_idx)
        LPMCS_IDX_MISC:   nxt_st.rdata = {28'h0, st_ff.misc};
        LPMCS_IDX_LPFLAG: nxt_st.rdata = {28'h0, st_ff.lpflag};
        LPMCS_IDX_RAMV:   nxt_st.rdata = {28'h0, st_ff.ramv};
        LPMCS_IDX_CSEL2:  nxt_st.rdata = {28'h0, st_ff.csel2};
        LPMCS_IDX_MODE:   nxt_st.rdata = {26'h0, st_ff.mode};
        default:          nxt_st.rdata = 32'h0; // write-only and unmapped read zero
      endcase
    end
    if (acc_done & pwrite) begin
      case (reg_idx)
        LPMCS_IDX_MISC:   nxt_st.misc = pwdata[3:0];
        LPMCS_IDX_LPFLAG: begin
          nxt_st.lpflag = pwdata[3:0];
          if (st_ff.mode != LPMCS_SUBACT) begin
            nxt_st.lpflag[LPMCS_DIRECT_BIT] = 1'b0;
          end
        end
        LPMCS_IDX_RAMV:   nxt_st.ramv = pwdata[3:0];
        LPMCS_IDX_CSEL1:  nxt_st.csel1 = pwdata[3:0];
        LPMCS_IDX_CSEL2:  nxt_st.csel2 = pwdata[3:0];
        default:          nxt_st.misc = st_ff.misc;
      endcase
    end

    // subsystem clock enable, divide ratio applies at once
    if (st_ff.mode != LPMCS_STOP && sub_osc_tick) begin
      if (st_ff.sub_cnt >= (st_ff.csel1[LPMCS_SUBDIV_BIT] ? LPMCS_SUBDIV4_LAST
                                                          : LPMCS_SUBDIV8_LAST)) begin
        nxt_st.sub_cnt = 3'h0;
        nxt_st.sub_en  = 1'b1;
      end else begin
        nxt_st.sub_cnt = st_ff.sub_cnt + 3'h1;
      end
    end

    // frame time base on the subclock; held in reset while in stop mode
    if (st_ff.mode == LPMCS_STOP) begin
      nxt_st.frame_cnt = '0;
      nxt_st.sub_cnt   = 3'h0;
    end else if (sub_osc_tick) begin
      if (st_ff.frame_cnt >= frame_last) begin
        nxt_st.frame_cnt = '0;
        nxt_st.strobe    = 1'b1;
      end else begin
        nxt_st.frame_cnt = st_ff.frame_cnt + FRM_W'(1);
      end
    end

    // timer a and ext_irq0_n requests: strobe-aligned in watch and subactive
    if (st_ff.mode == LPMCS_WATCH || st_ff.mode == LPMCS_SUBACT) begin
      if (tmr_a_ovf) begin
        nxt_st.tma_pend = 1'b1;
      end
      if (st_ff.strobe) begin
        // sampling once per frame is why short pulses on ext_irq0_n are missed
        nxt_st.ext_irq0_n_s1  = ext_irq0_n;
        nxt_st.ext_irq0_n_s2  = st_ff.ext_irq0_n_s1;
        nxt_st.ext_irq0_n_req = st_ff.ext_irq0_n_s2 & ~st_ff.ext_irq0_n_s1;
        nxt_st.tma_req  = st_ff.tma_pend | tmr_a_ovf;
        nxt_st.tma_pend = 1'b0;
      end
      nxt_st.ext_irq0_n_prev = ext_irq0_n;
    end else begin
      // other modes pass requests straight through, waking included
      nxt_st.tma_req   = tmr_a_ovf | st_ff.tma_pend;
      nxt_st.tma_pend  = 1'b0;
      nxt_st.ext_irq0_n_req  = st_ff.ext_irq0_n_prev & ~ext_irq0_n;
      nxt_st.ext_irq0_n_prev = ext_irq0_n;
      nxt_st.ext_irq0_n_s1   = ext_irq0_n;
      nxt_st.ext_irq0_n_s2   = ext_irq0_n;
    end
    wake_req = st_ff.tma_req | st_ff.ext_irq0_n_req;

    // mode sequencer
    case (st_ff.mode)
      LPMCS_ACTIVE: begin
        nxt_st.lpflag[LPMCS_DIRECT_BIT] = 1'b0;
        if (sleep_req & ~irq_enable_flag & irq_pending) begin
          nxt_st.nop = 1'b1;
        end else if (standby_instr) begin
          nxt_st.mode = LPMCS_STANDBY;
        end else if (stop_instr) begin
          nxt_st.mode = tma_watch_sel ? LPMCS_WATCH : LPMCS_STOP;
        end
      end
      LPMCS_STANDBY: begin
        if (irq_pending) begin
          nxt_st.mode = LPMCS_ACTIVE;
        end
      end
      LPMCS_SUBACT: begin
        if (sleep_req & ~irq_enable_flag & irq_pending) begin
          nxt_st.nop = 1'b1;
        end else if (sleep_req) begin
          if (~st_ff.lpflag[LPMCS_LOW_SPEED_BIT] & st_ff.lpflag[LPMCS_DIRECT_BIT]) begin
            // direct path passes through watch internally, so division updates
            nxt_st.mode       = LPMCS_WAKE;
            nxt_st.wake_sync  = 1'b1;
            nxt_st.settle_cnt = '0;
            nxt_st.sysdiv     = st_ff.csel2[1:0];
          end else begin
            nxt_st.mode = LPMCS_WATCH;
          end
        end
      end
      LPMCS_WATCH: begin
        if (wake_req) begin
          nxt_st.sysdiv = st_ff.csel2[1:0];
          if (st_ff.lpflag[LPMCS_LOW_SPEED_BIT]) begin
            nxt_st.mode = LPMCS_SUBACT;
          end else begin
            nxt_st.mode       = LPMCS_WAKE;
            nxt_st.wake_sync  = 1'b0;
            nxt_st.settle_cnt = '0;
          end
        end
      end
      LPMCS_STOP: begin
        // stop cancel is only looked at here, every other mode ignores it
        if (~stop_cancel_n) begin
          nxt_st.mode         = LPMCS_WAKE;
          nxt_st.wake_sync    = 1'b0;
          nxt_st.wake_restart = 1'b1;
          nxt_st.settle_cnt   = '0;
          nxt_st.strap_load   = 1'b1;
        end
      end
      LPMCS_WAKE: begin
        // internal processing ends at the next strobe, then the oscillator settles
        if (st_ff.wake_sync) begin
          if (st_ff.strobe) begin
            nxt_st.wake_sync = 1'b0;
          end
        end else if (st_ff.settle_cnt >= CNT_W'(SETTLE_CYC)) begin
          nxt_st.mode         = LPMCS_ACTIVE;
          nxt_st.restart      = st_ff.wake_restart;
          nxt_st.wake_restart = 1'b0;
          if (st_ff.wake_restart) begin
            nxt_st.ramv[LPMCS_RAM_VALID_BIT] = 1'b1;
          end
        end else begin
          nxt_st.settle_cnt = st_ff.settle_cnt + CNT_W'(1);
        end
      end
      default: nxt_st.mode = LPMCS_ACTIVE;
    endcase

    // division strap taken one cycle after reset or at stop exit
    if (st_ff.strap_load) begin
      nxt_st.sysdiv     = div_sel_pin ? LPMCS_DIV4 : LPMCS_DIV32;
      nxt_st.strap_load = 1'b0;
    end

    // oscillator and clock gating follow the next mode
    nxt_st.main_on = (nxt_st.mode == LPMCS_ACTIVE) | (nxt_st.mode == LPMCS_STANDBY)
                   | (nxt_st.mode == LPMCS_WAKE);
    nxt_st.sub_on  = ~((nxt_st.mode == LPMCS_STOP)
                   & st_ff.csel1[LPMCS_SUBOSC_STOP_BIT]);
    nxt_st.tone_on = (nxt_st.mode == LPMCS_ACTIVE) | (nxt_st.mode == LPMCS_STANDBY);
    nxt_st.cpu_on  = (nxt_st.mode == LPMCS_ACTIVE) | (nxt_st.mode == LPMCS_SUBACT);
  end

  // state register; reset wins over any mode, strap sampled after release
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff              <= '0;
      st_ff.mode         <= LPMCS_ACTIVE;
      st_ff.misc         <= LPMCS_MISC_RST;
      st_ff.lpflag       <= LPMCS_LPFLAG_RST;
      st_ff.ramv         <= LPMCS_RAMV_RST;
      st_ff.csel1        <= LPMCS_CSEL1_RST;
      st_ff.csel2        <= LPMCS_CSEL2_RST;
      st_ff.sysdiv       <= LPMCS_DIV32;
      st_ff.strap_load   <= 1'b1;
      st_ff.ext_irq0_n_s1      <= 1'b1;
      st_ff.ext_irq0_n_s2      <= 1'b1;
      st_ff.ext_irq0_n_prev    <= 1'b1;
      st_ff.main_on      <= 1'b1;
      st_ff.sub_on       <= 1'b1;
      st_ff.tone_on      <= 1'b1;
      st_ff.cpu_on       <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output but pslverr straight from the state register
  assign prdata       = st_ff.rdata;
  assign pready       = st_ff.ready;
  assign pslverr      = 1'b0;
  assign mode         = st_ff.mode;
  assign main_osc_on  = st_ff.main_on;
  assign sub_osc_on   = st_ff.sub_on;
  assign tone_gen_on  = st_ff.tone_on;
  assign cpu_clk_on   = st_ff.cpu_on;
  assign cpu_restart  = st_ff.restart;
  assign instr_nop    = st_ff.nop;
  assign sub_clk_en   = st_ff.sub_en;
  assign frame_strobe = st_ff.strobe;
  assign tma_irq_req  = st_ff.tma_req;
  assign ext_irq0_n_irq_req = st_ff.ext_irq0_n_req;
  assign sysdiv_eff   = st_ff.sysdiv;
  assign sysfreq_code = {st_ff.csel2[3:2], st_ff.csel1[1:0]};

endmodule

//--- lpmcs_props.sv
// concurrent checks on the sequencer ports
`timescale 1ns/10ps
module lpmcs_props
  import lpmcs_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = 20
) (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       stop_instr,
  input wire logic       standby_instr,
  input wire logic       irq_enable_flag,
  input wire logic       irq_pending,
  input wire logic       stop_cancel_n,
  input wire logic       div_sel_pin,
  input wire logic [5:0] mode,
  input wire logic       main_osc_on,
  input wire logic       tone_gen_on,
  input wire logic       cpu_restart,
  input wire logic       instr_nop,
  input wire logic       frame_strobe,
  input wire logic       tma_irq_req,
  input wire logic       ext_irq0_n_irq_req,
  input wire logic [1:0] sysdiv_eff
);
  // wake lasts the settle count plus one before active
  localparam int WAKE_DLY = SETTLE_CYC + 1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_rst_active;
    $fell(srst) |-> mode == LPMCS_ACTIVE;
  endproperty
  a_rst_active: assert property (p_rst_active)
    else $error("mode not active after reset");
  property p_sub_osc;
    mode == LPMCS_SUBACT && $past(mode) == LPMCS_SUBACT |-> !main_osc_on && !tone_gen_on;
  endproperty
  a_sub_osc: assert property (p_sub_osc)
    else $error("main osc or tone on in subactive");
  property p_act_hold;
    mode == LPMCS_ACTIVE && !stop_instr && !standby_instr |=> mode == LPMCS_ACTIVE;
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("active left without sleep");
  property p_cancel;
    mode == LPMCS_STOP && !stop_cancel_n
      |=> mode == LPMCS_WAKE ##WAKE_DLY (mode == LPMCS_ACTIVE && cpu_restart);
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("stop cancel did not restart");
  property p_strap;
    cpu_restart |=> sysdiv_eff == (div_sel_pin ? LPMCS_DIV4 : LPMCS_DIV32);
  endproperty
  a_strap: assert property (p_strap)
    else $error("division not strap after stop exit");
  property p_nop;
    mode == LPMCS_ACTIVE && (stop_instr || standby_instr) && !irq_enable_flag
      && irq_pending |=> instr_nop && mode == LPMCS_ACTIVE;
  endproperty
  a_nop: assert property (p_nop)
    else $error("sleep not treated as no-op");
  property p_tma_align;
    tma_irq_req && mode == LPMCS_WATCH |-> frame_strobe || $past(frame_strobe);
  endproperty
  a_tma_align: assert property (p_tma_align)
    else $error("timer request off strobe");
  property p_watch_exit;
    mode == LPMCS_WATCH && (tma_irq_req || ext_irq0_n_irq_req)
      |-> ##[1:2] (mode == LPMCS_SUBACT || mode == LPMCS_WAKE);
  endproperty
  a_watch_exit: assert property (p_watch_exit)
    else $error("watch not left on request");
endmodule

//--- lpmcs_partner.sv
// subclock crystal and ext_irq0_n source outside the sequencer
`timescale 1ns/10ps
module lpmcs_partner #(
  parameter int TICK_CYC = 4,
  parameter int HOLD     = 80
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic fire,
  output logic      sub_osc_tick,
  output logic      ext_irq0_n
);
  int tick_cnt = 0;
  int low_cnt  = 0;
  // crystal runs free, even in reset, like the real part
  always_ff @(posedge core_clk) begin
    tick_cnt <= (tick_cnt >= TICK_CYC - 1) ? 0 : tick_cnt + 1;
    if (srst) begin
      low_cnt <= 0;
    end else if (fire) begin
      low_cnt <= HOLD;
    end else if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
    end
  end
  assign sub_osc_tick = (tick_cnt == TICK_CYC - 1);
  // low far longer than a frame, else the edge would be lost
  assign ext_irq0_n = (low_cnt == 0);
endmodule

//--- lpmcs_bench.sv
// self-checking bench for the low-power mode sequencer
`timescale 1ns/10ps
module lpmcs_bench
  import lpmcs_pkg::*;
;
  localparam int SC = 20;
  logic core_clk = 1'b0;
  logic srst, psel, penable, pwrite, stop_instr, standby_instr, tma_watch_sel;
  logic irq_enable_flag, irq_pending, stop_cancel_n, tmr_a_ovf, div_sel_pin, fire;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, sub_osc_tick, ext_irq0_n, main_osc_on, tone_gen_on, cpu_restart;
  logic instr_nop, sub_clk_en, frame_strobe, tma_irq_req, ext_irq0_n_irq_req;
  logic pslverr, sub_osc_on, cpu_clk_on;
  logic [3:0] sysfreq_code;
  logic [5:0] mode;
  logic [1:0] sysdiv_eff;
  int bad_count = 0;
  int n_checks = 0;

  always #2.5 core_clk = ~core_clk;

  lpmcs_top #(.SETTLE_CYC(SC)) uut (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_instr(stop_instr), .standby_instr(standby_instr), .tma_watch_sel(tma_watch_sel),
    .irq_enable_flag(irq_enable_flag), .irq_pending(irq_pending),
    .stop_cancel_n(stop_cancel_n), .ext_irq0_n(ext_irq0_n), .tmr_a_ovf(tmr_a_ovf),
    .sub_osc_tick(sub_osc_tick), .div_sel_pin(div_sel_pin), .mode(mode),
    .main_osc_on(main_osc_on), .sub_osc_on(sub_osc_on), .tone_gen_on(tone_gen_on),
    .cpu_clk_on(cpu_clk_on),
    .cpu_restart(cpu_restart), .instr_nop(instr_nop), .sub_clk_en(sub_clk_en),
    .frame_strobe(frame_strobe), .tma_irq_req(tma_irq_req), .ext_irq0_n_irq_req(ext_irq0_n_irq_req),
    .sysdiv_eff(sysdiv_eff), .sysfreq_code(sysfreq_code)
  );
  lpmcs_partner u_partner (.core_clk(core_clk), .srst(srst), .fire(fire),
    .sub_osc_tick(sub_osc_tick), .ext_irq0_n(ext_irq0_n));

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask
  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'b1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait for pready
    do begin @(posedge core_clk); end while (pready !== 1'b1);
    q = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0; penable <= 1'b0;
    // one idle edge, so a following call never reassigns psel in this time step
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, i, d, q);
  endtask
  task automatic rd(input string nm, input logic [11:0] i, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, i, 32'h0, q);
    chk(nm, e, q);
  endtask
  // bounded wait; a hang shows up as a wrong mode
  task automatic wmode(input logic [5:0] m, output int n);
    n = 0;
    do begin @(posedge core_clk); n++; end while (mode !== m && n < 3000);
    chk("mode", {26'h0, m}, {26'h0, mode});
  endtask
  task automatic sleep(input logic sb);
    if (sb) standby_instr <= 1'b1; else stop_instr <= 1'b1;
    @(posedge core_clk);
    standby_instr <= 1'b0; stop_instr <= 1'b0;
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin @(posedge core_clk); n++; end while (sub_clk_en !== 1'b1 && n < 99);
  endtask

  task automatic t_regs;
    int n;
    rd("misc", LPMCS_IDX_MISC, {28'h0, LPMCS_MISC_RST});
    rd("ramv", LPMCS_IDX_RAMV, 32'h0);
    rd("csel1", LPMCS_IDX_CSEL1, 32'h0);
    rd("unmapped", 12'h03e, 32'h0);
    wr(LPMCS_IDX_LPFLAG, 32'h9);
    rd("flags", LPMCS_IDX_LPFLAG, 32'h1);
    wr(LPMCS_IDX_CSEL2, 32'h1);
    chk("sysdiv", {30'h0, LPMCS_DIV4}, {30'h0, sysdiv_eff});
    for (int v = 0; v < 2; v++) begin
      wr(LPMCS_IDX_CSEL1, v ? 32'h7 : 32'h0);
      gap(n);
      gap(n);
      chk("subclk gap", v ? 32'd16 : 32'd32, n);
      chk("sysfreq", v ? 32'h3 : 32'h0, {28'h0, sysfreq_code});
    end
    $display("t_regs done");
  endtask
  task automatic t_nop;
    int n;
    irq_pending <= 1'b1;
    stop_cancel_n <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      sleep(k[0]);
      @(posedge core_clk);
      chk("nop", 32'h1, {31'h0, instr_nop});
      chk("mode", {26'h0, LPMCS_ACTIVE}, {26'h0, mode});
    end
    irq_pending <= 1'b0;
    sleep(1'b1);
    wmode(LPMCS_STANDBY, n);
    irq_pending <= 1'b1;
    wmode(LPMCS_ACTIVE, n);
    irq_pending <= 1'b0;
    stop_cancel_n <= 1'b1;
    $display("t_nop done");
  endtask
  task automatic t_stop;
    int n;
    tma_watch_sel <= 1'b0;
    wr(LPMCS_IDX_CSEL1, 32'hc);
    sleep(1'b0);
    wmode(LPMCS_STOP, n);
    chk("sub osc", 32'h0, {31'h0, sub_osc_on});
    chk("cpu clk", 32'h0, {31'h0, cpu_clk_on});
    // strap low so the exit division differs from the one before stop
    div_sel_pin <= 1'b0;
    stop_cancel_n <= 1'b0;
    wmode(LPMCS_ACTIVE, n);
    chk("restart", 32'h1, {31'h0, cpu_restart});
    stop_cancel_n <= 1'b1;
    chk("sub osc", 32'h1, {31'h0, sub_osc_on});
    rd("ramv", LPMCS_IDX_RAMV, 32'h8);
    chk("sysdiv", {30'h0, LPMCS_DIV32}, {30'h0, sysdiv_eff});
    div_sel_pin <= 1'b1;
    $display("t_stop done");
  endtask
  task automatic t_direct;
    int n;
    wr(LPMCS_IDX_LPFLAG, 32'h1);
    tma_watch_sel <= 1'b1;
    sleep(1'b0);
    wmode(LPMCS_WATCH, n);
    for (int k = 0; k < 2; k++) begin
      tmr_a_ovf <= 1'b1;
      @(posedge core_clk);
      tmr_a_ovf <= 1'b0;
      wmode(LPMCS_SUBACT, n);
      if (k == 0) begin
        sleep(1'b1);
        wmode(LPMCS_WATCH, n);
      end
    end
    chk("main osc", 32'h0, {31'h0, main_osc_on});
    chk("tone", 32'h0, {31'h0, tone_gen_on});
    chk("cpu clk", 32'h1, {31'h0, cpu_clk_on});
    wr(LPMCS_IDX_LPFLAG, 32'h8);
    rd("flags", LPMCS_IDX_LPFLAG, 32'h8);
    wr(LPMCS_IDX_CSEL2, 32'h2);
    sleep(1'b1);
    wmode(LPMCS_ACTIVE, n);
    chk("direct time", 32'h1, {31'h0, n > SC && n < SC + 36});
    chk("sysdiv", 32'h2, {30'h0, sysdiv_eff});
    rd("flags", LPMCS_IDX_LPFLAG, 32'h0);
    $display("t_direct done");
  endtask
  task automatic t_ext_irq0_n;
    int n;
    int s;
    wr(LPMCS_IDX_LPFLAG, 32'h0);
    sleep(1'b0);
    wmode(LPMCS_WATCH, n);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    n = 0;
    s = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (frame_strobe === 1'b1) s++;
    end while (ext_irq0_n_irq_req !== 1'b1 && n < 500);
    chk("strobes", 32'd2, s);
    wmode(LPMCS_ACTIVE, n);
    $display("t_ext_irq0_n done");
  endtask

  // whole run takes under a thousand cycles; 20000 means a hang
  initial begin
    #100000;
    $display("ERROR watchdog expected finish seen timeout");
    bad_count++;
    test_done;
  end
  initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 14'h0;
    pwdata = 32'h0; stop_instr = 1'b0; standby_instr = 1'b0; tma_watch_sel = 1'b0;
    irq_enable_flag = 1'b0; irq_pending = 1'b0; stop_cancel_n = 1'b1;
    tmr_a_ovf = 1'b0; div_sel_pin = 1'b1; fire = 1'b0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_regs;
    t_nop;
    t_stop;
    t_direct;
    t_ext_irq0_n;
    test_done;
  end
endmodule

bind lpmcs_top lpmcs_props #(.SETTLE_CYC(SETTLE_CYC)) u_props (
  .core_clk(core_clk), .srst(srst), .stop_instr(stop_instr),
  .standby_instr(standby_instr), .irq_enable_flag(irq_enable_flag),
  .irq_pending(irq_pending), .stop_cancel_n(stop_cancel_n), .div_sel_pin(div_sel_pin),
  .mode(mode), .main_osc_on(main_osc_on), .tone_gen_on(tone_gen_on),
  .cpu_restart(cpu_restart), .instr_nop(instr_nop), .frame_strobe(frame_strobe),
  .tma_irq_req(tma_irq_req), .ext_irq0_n_irq_req(ext_irq0_n_irq_req), .sysdiv_eff(sysdiv_eff)
);
